// ---- rcm_cfg.svh ----
// Constants for the remote control mode selection block.
`ifndef RCM_CFG_SVH
`define RCM_CFG_SVH

`define RCM_WORD_BITS    31
`define RCM_SEC_BITS     22
`define RCM_CFG_BITS     9
`define RCM_SEC_LSB      9
`define RCM_CFG_LSB      0
`define RCM_CFG_D_BIT    5
`define RCM_CFG_E_BIT    4
`define RCM_CFG_INV_BIT  0
`define RCM_CFG_TX_BIT   8
`define RCM_CFG_RST      9'h000
`define RCM_WORD_RST     31'h0000_0000
`define RCM_POR_CLKS     3'h4
`define RCM_TEST_PULSES  2'h3
`define RCM_FIFO_DEPTH   32
`define RCM_FIFO_WIDTH   1
`define RCM_NUM_MODES    5
`define RCM_NUM_CFGS     66
`define RCM_NUM_RX_CFGS  48
`define RCM_NUM_TX_CFGS  18

`endif

// ---- rcm_pkg.sv ----
// Types shared by the remote control mode selection block.
package rcm_pkg;

    typedef enum logic [2:0] {
        MODE_INIT     = 3'h0,
        MODE_AMP_TEST = 3'h1,
        MODE_PROGRAM  = 3'h2,
        MODE_READ     = 3'h3,
        MODE_TX       = 3'h4,
        MODE_RX       = 3'h5,
        MODE_UNSUP    = 3'h6
    } rcm_mode_t;

    typedef enum logic [3:0] {
        TX_NONE      = 4'h0,
        TX_NORM_CONT = 4'h1,
        TX_NORM_TRIG = 4'h2,
        TX_NORM_PER  = 4'h3,
        TX_MOD_TRIG  = 4'h4,
        TX_MOD_CONT  = 4'h5,
        TX_MOD_PER   = 4'h6
    } rcm_txcfg_t;

    typedef enum logic [1:0] {
        RX_NONE   = 2'h0,
        RX_ANALOG = 2'h1,
        RX_MOD    = 2'h2,
        RX_LOGIC  = 2'h3
    } rcm_rxcls_t;

    typedef enum logic [0:0] {
        PS_POR = 1'h0,
        PS_RUN = 1'h1
    } rcm_por_t;

endpackage

// ---- rcm_pulse_if.sv ----
// Interface between the mode selector and the test pulse counter.
`timescale 1ns/10ps
interface rcm_pulse_if;
    logic       hv;
    logic       res_level;
    logic [1:0] count;
    logic       test_seen;
    modport ctl (output hv, output res_level, input count, input test_seen);
    modport cnt (input hv, input res_level, output count, output test_seen);
endinterface

// ---- rcm_fifo.sv ----
// Parameterised valid/ready FIFO for the serial data path.
`timescale 1ns/10ps
module rcm_fifo #(
    parameter int W = 1,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  wr_ptr_next;
    logic [AW:0]  rd_ptr_reg;
    logic [AW:0]  rd_ptr_next;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    always_comb begin
        full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
        empty       = (wr_ptr_reg == rd_ptr_reg);
        push        = in_valid && !full;
        pop         = out_ready && !empty;
        wr_ptr_next = push ? wr_ptr_reg + 1'h1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'h1 : rd_ptr_reg;
        in_ready    = !full;
        out_valid   = !empty;
        out_data    = mem[rd_ptr_reg[AW-1:0]];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // Storage has no reset; only entries behind the write pointer are ever read.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

// ---- rcm_pulse_cnt.sv ----
// Counts low pulses on the resistor oscillator pin while over-voltage is seen.
`timescale 1ns/10ps
`include "rcm_cfg.svh"
module rcm_pulse_cnt (
    input wire logic clk,
    input wire logic rst_n,
    rcm_pulse_if.cnt pif
);
    logic       res_prev_reg;
    logic       res_prev_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;

    always_comb begin
        res_prev_next = pif.res_level;
        count_next    = count_reg;
        if (!pif.hv) begin
            count_next = 2'h0;
        end else if (res_prev_reg && !pif.res_level &&
                     count_reg != `RCM_TEST_PULSES) begin
            count_next = count_reg + 2'h1;
        end
        pif.count     = count_reg;
        pif.test_seen = (count_reg == `RCM_TEST_PULSES);
    end

    // The count saturates, so any number of pulses beyond three still means test.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_prev_reg <= 1'h0;
            count_reg    <= 2'h0;
        end else begin
            res_prev_reg <= res_prev_next;
            count_reg    <= count_next;
        end
    end
endmodule

// ---- rcm_mode_select.sv ----
// Mode and configuration selection for the remote control transmitter/receiver.
`timescale 1ns/10ps
`include "rcm_cfg.svh"
// Notes on behaviour
// - Five primary modes: amplifier test, program, read, transmitter, receiver.
// - Sixty-six configurations: forty-eight receiver and eighteen transmitter.
// - Over-voltage plus three or more low pulses enters amplifier test; the code selects program mode instead while PROG_SEL is high.
// - In amplifier test the comparator output drives the timing pin.
// - In receiver mode the comparator output feeds the internal receive logic.
// - Receive amplifier is enabled for analog and modulated receiver configurations.
// - Logic receiver configurations disable and bypass the amplifier.
// - The comparator shapes and inverts the received waveform.
// - Normal transmitter continuous, triggered and periodic patterns are decoded.
// - Modulated transmitter triggered, continuous and periodic patterns are decoded.
// - Triggered transmitters send while the timing pin is held low.
// - Transmitter serial output sends stored code and configuration bit by bit.
// - After power-on reset the nine configuration bits are loaded.
// - Stored word: twenty-two security code bits, then nine configuration bits.
module rcm_mode_select
    import rcm_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        OSC_CAP_HV,
    input  wire logic        OSC_RES_PIN,
    input  wire logic        PROG_SEL,
    input  wire logic [30:0] STORED_WORD,
    input  wire logic        AMP_IN,
    input  wire logic        TIME_IN,
    input  wire logic        SER_READY,
    output logic [2:0]       MODE,
    output logic [3:0]       TX_CFG,
    output logic [1:0]       CODE_SEL,
    output logic             RX_INVERT,
    output logic             CFG_UNSUPPORTED,
    output logic             CFG_LOADED,
    output logic             AMP_EN,
    output logic             TIME_OUT,
    output logic             TIME_OE,
    output logic             RX_DATA,
    output logic             TX_ACTIVE,
    output logic             SER_OUT,
    output logic             SER_VALID
);
    rcm_pulse_if pif ();

    rcm_por_t   por_reg;
    rcm_por_t   por_next;
    logic [2:0] por_cnt_reg;
    logic [2:0] por_cnt_next;
    logic [8:0] cfg_reg;
    logic [8:0] cfg_next;
    logic [30:0] word_reg;
    logic [30:0] word_next;
    logic       loaded_reg;
    logic       loaded_next;

    rcm_mode_t  mode_reg;
    rcm_mode_t  mode_next;
    rcm_txcfg_t txcfg_reg;
    rcm_txcfg_t txcfg_next;
    rcm_rxcls_t rxcls;
    rcm_txcfg_t txcls;
    logic [1:0] code_sel_reg;
    logic [1:0] code_sel_next;
    logic       inv_reg;
    logic       inv_next;
    logic       unsup_reg;
    logic       unsup_next;
    logic       amp_en_reg;
    logic       amp_en_next;
    logic       time_out_reg;
    logic       time_out_next;
    logic       time_oe_reg;
    logic       time_oe_next;
    logic       rx_data_reg;
    logic       rx_data_next;
    logic       comp_out;

    logic [30:0] shift_reg;
    logic [30:0] shift_next;
    logic [4:0]  left_reg;
    logic [4:0]  left_next;
    logic        tx_go;
    logic        tx_active_reg;
    logic        tx_active_next;
    logic        ser_out_reg;
    logic        ser_out_next;
    logic        ser_valid_reg;
    logic        ser_valid_next;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [0:0]  fifo_out_data;

    function automatic rcm_txcfg_t tx_decode(input logic [8:0] c);
        casez (c)
            9'b11100000?: tx_decode = TX_NORM_CONT;
            9'b110??0001: tx_decode = TX_NORM_TRIG;
            9'b110??0000: tx_decode = TX_NORM_PER;
            9'b100??0001: tx_decode = TX_MOD_TRIG;
            9'b10100000?: tx_decode = TX_MOD_CONT;
            9'b100??0000: tx_decode = TX_MOD_PER;
            default:      tx_decode = TX_NONE;
        endcase
    endfunction

    function automatic rcm_rxcls_t rx_decode(input logic [8:0] c);
        casez (c)
            9'b010??010?, 9'b010??011?, 9'b010??000?: rx_decode = RX_ANALOG;
            9'b000???10?, 9'b000???11?, 9'b000???00?: rx_decode = RX_MOD;
            9'b010??110?, 9'b010??111?, 9'b010??100?: rx_decode = RX_LOGIC;
            default:                                  rx_decode = RX_NONE;
        endcase
    endfunction

    assign pif.hv        = OSC_CAP_HV;
    assign pif.res_level = OSC_RES_PIN;

    rcm_pulse_cnt u_pulse_cnt (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .pif   (pif.cnt)
    );

    // Power-on wait of four clocks, then the stored word is captured.
    always_comb begin
        por_next     = por_reg;
        por_cnt_next = por_cnt_reg;
        cfg_next     = cfg_reg;
        word_next    = word_reg;
        loaded_next  = loaded_reg;
        case (por_reg)
            PS_POR: begin
                if (por_cnt_reg == `RCM_POR_CLKS - 3'h1) begin
                    por_next    = PS_RUN;
                    word_next   = STORED_WORD;
                    cfg_next    = STORED_WORD[`RCM_CFG_LSB +: `RCM_CFG_BITS];
                    loaded_next = 1'h1;
                end else begin
                    por_cnt_next = por_cnt_reg + 3'h1;
                end
            end
            PS_RUN: begin
                por_next = PS_RUN;
            end
            default: begin
                por_next = PS_POR;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            por_reg     <= PS_POR;
            por_cnt_reg <= 3'h0;
            cfg_reg     <= `RCM_CFG_RST;
            word_reg    <= `RCM_WORD_RST;
            loaded_reg  <= 1'h0;
        end else begin
            por_reg     <= por_next;
            por_cnt_reg <= por_cnt_next;
            cfg_reg     <= cfg_next;
            word_reg    <= word_next;
            loaded_reg  <= loaded_next;
        end
    end

    // Mode choice and pin steering. Over-voltage overrides the stored configuration.
    always_comb begin
        txcls         = tx_decode(cfg_reg);
        rxcls         = rx_decode(cfg_reg);
        comp_out      = !AMP_IN;
        mode_next     = MODE_INIT;
        txcfg_next    = TX_NONE;
        code_sel_next = 2'h0;
        inv_next      = 1'h0;
        unsup_next    = 1'h0;
        amp_en_next   = 1'h0;
        time_oe_next  = 1'h0;
        time_out_next = 1'h0;
        rx_data_next  = 1'h0;
        if (OSC_CAP_HV) begin
            if (PROG_SEL) begin
                mode_next = MODE_PROGRAM;
            end else if (pif.test_seen) begin
                mode_next     = MODE_AMP_TEST;
                amp_en_next   = 1'h1;
                time_oe_next  = 1'h1;
                time_out_next = comp_out;
            end else begin
                mode_next = MODE_READ;
            end
        end else if (loaded_reg) begin
            if (cfg_reg[`RCM_CFG_TX_BIT]) begin
                txcfg_next    = txcls;
                mode_next     = (txcls == TX_NONE) ? MODE_UNSUP : MODE_TX;
                unsup_next    = (txcls == TX_NONE);
                code_sel_next = {cfg_reg[`RCM_CFG_D_BIT], cfg_reg[`RCM_CFG_E_BIT]};
            end else begin
                mode_next    = (rxcls == RX_NONE) ? MODE_UNSUP : MODE_RX;
                unsup_next   = (rxcls == RX_NONE);
                inv_next     = cfg_reg[`RCM_CFG_INV_BIT];
                code_sel_next = {cfg_reg[`RCM_CFG_D_BIT], cfg_reg[`RCM_CFG_E_BIT]};
                amp_en_next  = (rxcls == RX_ANALOG) || (rxcls == RX_MOD);
                // Logic receivers leave the amplifier off but still pass the inverted comparator output.
                rx_data_next = (rxcls == RX_NONE) ? 1'h0 : comp_out;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mode_reg     <= MODE_INIT;
            txcfg_reg    <= TX_NONE;
            code_sel_reg <= 2'h0;
            inv_reg      <= 1'h0;
            unsup_reg    <= 1'h0;
            amp_en_reg   <= 1'h0;
            time_out_reg <= 1'h0;
            time_oe_reg  <= 1'h0;
            rx_data_reg  <= 1'h0;
        end else begin
            mode_reg     <= mode_next;
            txcfg_reg    <= txcfg_next;
            code_sel_reg <= code_sel_next;
            inv_reg      <= inv_next;
            unsup_reg    <= unsup_next;
            amp_en_reg   <= amp_en_next;
            time_out_reg <= time_out_next;
            time_oe_reg  <= time_oe_next;
            rx_data_reg  <= rx_data_next;
        end
    end

    // Serialiser: stored word, security code first, pushed into the FIFO.
    always_comb begin
        case (txcfg_reg)
            TX_NORM_TRIG, TX_MOD_TRIG: tx_go = !TIME_IN;
            TX_NORM_CONT, TX_MOD_CONT,
            TX_NORM_PER, TX_MOD_PER:   tx_go = 1'h1;
            default:                   tx_go = 1'h0;
        endcase
        if (mode_reg != MODE_TX) begin
            tx_go = 1'h0;
        end
        shift_next     = shift_reg;
        left_next      = left_reg;
        fifo_in_valid  = (left_reg != 5'h00);
        tx_active_next = tx_go || (left_reg != 5'h00);
        if (left_reg == 5'h00) begin
            if (tx_go) begin
                shift_next = word_reg;
                left_next  = 5'(`RCM_WORD_BITS);
            end
        end else if (fifo_in_ready) begin
            shift_next = {shift_reg[29:0], 1'h0};
            left_next  = left_reg - 5'h01;
        end
        // The output flop reloads only when empty or taken, so back-pressure stalls the FIFO.
        fifo_out_ready = !ser_valid_reg || SER_READY;
        ser_out_next   = ser_out_reg;
        ser_valid_next = ser_valid_reg;
        if (fifo_out_ready) begin
            ser_valid_next = fifo_out_valid;
            ser_out_next   = fifo_out_valid ? fifo_out_data[0] : 1'h0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            shift_reg     <= `RCM_WORD_RST;
            left_reg      <= 5'h00;
            tx_active_reg <= 1'h0;
            ser_out_reg   <= 1'h0;
            ser_valid_reg <= 1'h0;
        end else begin
            shift_reg     <= shift_next;
            left_reg      <= left_next;
            tx_active_reg <= tx_active_next;
            ser_out_reg   <= ser_out_next;
            ser_valid_reg <= ser_valid_next;
        end
    end

    rcm_fifo #(
        .W (`RCM_FIFO_WIDTH),
        .D (`RCM_FIFO_DEPTH)
    ) u_fifo (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (shift_reg[30]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign MODE            = mode_reg;
    assign TX_CFG          = txcfg_reg;
    assign CODE_SEL        = code_sel_reg;
    assign RX_INVERT       = inv_reg;
    assign CFG_UNSUPPORTED = unsup_reg;
    assign CFG_LOADED      = loaded_reg;
    assign AMP_EN          = amp_en_reg;
    assign TIME_OUT        = time_out_reg;
    assign TIME_OE         = time_oe_reg;
    assign RX_DATA         = rx_data_reg;
    assign TX_ACTIVE       = tx_active_reg;
    assign SER_OUT         = ser_out_reg;
    assign SER_VALID       = ser_valid_reg;
endmodule

// ---- rcm_mode_select_properties.sv ----
// Concurrent checks on the ports of the mode selector.
`timescale 1ns/10ps
module rcm_mode_select_chk (
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire logic       OSC_CAP_HV,
    input wire logic       PROG_SEL,
    input wire logic       AMP_IN,
    input wire logic       SER_READY,
    input wire logic [2:0] MODE,
    input wire logic       CFG_UNSUPPORTED,
    input wire logic       CFG_LOADED,
    input wire logic       AMP_EN,
    input wire logic       TIME_OUT,
    input wire logic       TIME_OE,
    input wire logic       RX_DATA,
    input wire logic       SER_OUT,
    input wire logic       SER_VALID
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    a_reset_clear: assert property (!$past(RST_N) |-> (MODE == 3'h0 && !CFG_LOADED)[*2])
        else $error("outputs not cleared after reset");
    a_load_time: assert property ($rose(RST_N) |-> (!CFG_LOADED)[*4] ##1 CFG_LOADED)
        else $error("configuration not loaded on the fourth edge");
    a_prog_select: assert property (
        $past(CFG_LOADED) && $past(OSC_CAP_HV) && $past(PROG_SEL) |-> MODE == 3'h2)
        else $error("program mode not selected");
    // The timing pin carries the inverted comparator result only in amplifier test.
    a_amp_test_pin: assert property (
        MODE == 3'h1 && $past(MODE) == 3'h1 |-> TIME_OE && AMP_EN && TIME_OUT == !$past(AMP_IN))
        else $error("amplifier output not on timing pin");
    a_pin_idle: assert property (
        MODE != 3'h1 && $past(MODE) != 3'h1 |-> !TIME_OE && !TIME_OUT)
        else $error("timing pin driven outside test");
    a_rx_data: assert property (
        MODE == 3'h5 && $past(MODE) == 3'h5 |-> RX_DATA == !$past(AMP_IN))
        else $error("received data not inverted comparator output");
    a_amp_off: assert property (
        (MODE == 3'h4 || MODE == 3'h6) && $stable(MODE) |-> !AMP_EN)
        else $error("amplifier enabled outside receiver");
    a_unsup_quiet: assert property (
        CFG_UNSUPPORTED && $past(CFG_LOADED) && !$past(OSC_CAP_HV) && !$past(OSC_CAP_HV, 2)
        |-> MODE == 3'h6 && !RX_DATA && !SER_VALID)
        else $error("unsupported configuration not quiet");
    a_ser_hold: assert property (SER_VALID && !SER_READY |=> SER_VALID && $stable(SER_OUT))
        else $error("serial bit dropped before acceptance");
endmodule

bind rcm_mode_select rcm_mode_select_chk u_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .OSC_CAP_HV(OSC_CAP_HV), .PROG_SEL(PROG_SEL),
    .AMP_IN(AMP_IN), .SER_READY(SER_READY), .MODE(MODE), .CFG_UNSUPPORTED(CFG_UNSUPPORTED),
    .CFG_LOADED(CFG_LOADED), .AMP_EN(AMP_EN), .TIME_OUT(TIME_OUT), .TIME_OE(TIME_OE),
    .RX_DATA(RX_DATA), .SER_OUT(SER_OUT), .SER_VALID(SER_VALID)
);

// ---- rcm_ser_sink.sv ----
// Serial consumer standing in for the matching receiver on the data output.
`timescale 1ns/10ps
module rcm_ser_sink (
    input  wire logic       clk,
    input  wire logic [1:0] pace,
    output logic            ser_ready
);
    int stall_cnt;
    initial begin
        ser_ready = 1'b0;
        stall_cnt = 0;
    end
    // Pace 2 holds off long enough to fill the buffer, then turns random.
    always @(posedge clk) begin
        #1;
        stall_cnt = (pace == 2'h2) ? stall_cnt + 1 : 0;
        if (pace == 2'h0) begin
            ser_ready = 1'b1;
        end else if (pace == 2'h2 && stall_cnt < 80) begin
            ser_ready = 1'b0;
        end else begin
            ser_ready = 1'($urandom_range(1, 0));
        end
    end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the remote control mode selector.
`timescale 1ns/10ps
module testbench;
    localparam logic [8:0] CFG_TAB [16] = '{9'h1C0, 9'h181, 9'h180, 9'h101, 9'h140, 9'h100,
        9'h084, 9'h086, 9'h080, 9'h004, 9'h006, 9'h000, 9'h08C, 9'h08E, 9'h088, 9'h1FF};
    localparam logic [8:0] FREE_TAB [16] = '{9'h001, 9'h030, 9'h030, 9'h030, 9'h001, 9'h030,
        9'h031, 9'h031, 9'h031, 9'h039, 9'h039, 9'h039, 9'h031, 9'h031, 9'h031, 9'h000};
    localparam logic [15:0] DE_CHK = 16'h6DAE;
    localparam logic [15:0] AMP_ON = 16'h0FC0;
    localparam logic [15:0] TX_GO  = 16'h0035;
    logic        clk;
    logic        rst_n;
    logic        hv;
    logic        res_pin;
    logic        prog_sel;
    logic [30:0] word;
    logic        amp_in;
    logic        time_in;
    logic [1:0]  pace;
    logic        ser_ready;
    logic [2:0]  mode;
    logic [3:0]  tx_cfg;
    logic [1:0]  code_sel;
    logic        rx_invert;
    logic        unsup;
    logic        loaded;
    logic        amp_en;
    logic        time_oe;
    logic        rx_data;
    logic        tx_active;
    logic        ser_out;
    logic        ser_valid;
    logic        exp_q [$];
    int          err_count;
    int          check_count;

    rcm_mode_select DUT (
        .REF_CLK(clk), .RST_N(rst_n), .OSC_CAP_HV(hv), .OSC_RES_PIN(res_pin),
        .PROG_SEL(prog_sel), .STORED_WORD(word), .AMP_IN(amp_in), .TIME_IN(time_in),
        .SER_READY(ser_ready), .MODE(mode), .TX_CFG(tx_cfg), .CODE_SEL(code_sel),
        .RX_INVERT(rx_invert), .CFG_UNSUPPORTED(unsup), .CFG_LOADED(loaded),
        .AMP_EN(amp_en), .TIME_OUT(), .TIME_OE(time_oe), .RX_DATA(rx_data),
        .TX_ACTIVE(tx_active), .SER_OUT(ser_out), .SER_VALID(ser_valid)
    );
    rcm_ser_sink u_sink (.clk(clk), .pace(pace), .ser_ready(ser_ready));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_v(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: serial bit %b expected %b", $time, got, exp);
        end
    endtask

    // A fresh reset is the only way to make the selector take a new stored word.
    task automatic load(input logic [30:0] w);
        rst_n = 1'b0;
        word = w;
        tick(2);
        rst_n = 1'b1;
        tick(3);
        chk_v(4'(mode), 4'h0);
        chk_v(4'(loaded), 4'h0);
        tick(7);
    endtask

    task automatic push_word(input logic [30:0] w, input int reps);
        repeat (reps) begin
            for (int b = 30; b >= 0; b--) begin
                exp_q.push_back(w[b]);
            end
        end
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() > 0 && n < 2000) begin
            tick(1);
            n++;
        end
        if (exp_q.size() > 0) begin
            err_count++;
            $display("wrong value at %0t: serial stream stalled", $time);
            summarize();
        end
    endtask

    task automatic falls(input int n);
        repeat (n) begin
            res_pin = 1'b1;
            tick(1);
            res_pin = 1'b0;
            tick(1);
        end
        tick(3);
    endtask

    always @(posedge clk) begin
        #1;
        amp_in = 1'($urandom_range(1, 0));
    end

    always @(posedge clk) begin
        if (rst_n && ser_valid && ser_ready && exp_q.size() > 0) begin
            chk_bit(ser_out, exp_q.pop_front());
        end
    end

    initial begin
        logic [30:0] w;
        void'($urandom(88));
        rst_n = 1'b0;
        hv = 1'b0;
        res_pin = 1'b0;
        prog_sel = 1'b0;
        word = 31'h0000_0000;
        amp_in = 1'b0;
        time_in = 1'b1;
        pace = 2'h0;
        err_count = 0;
        check_count = 0;
        tick(20);
        for (int i = 0; i < 16; i++) begin
            w = {22'($urandom), CFG_TAB[i] | (9'($urandom) & FREE_TAB[i])};
            load(w);
            chk_v(4'(mode), (i < 6) ? 4'h4 : (i < 15) ? 4'h5 : 4'h6);
            chk_v(tx_cfg, (i < 6) ? 4'(i + 1) : 4'h0);
            chk_v(4'(amp_en), 4'(AMP_ON[i]));
            chk_v(4'(unsup), 4'(i == 15));
            chk_v(4'(loaded), 4'h1);
            chk_v(4'(tx_active), 4'(TX_GO[i]));
            if (DE_CHK[i]) begin
                chk_v(4'(code_sel), 4'(w[5:4]));
            end
            if (i > 5 && i < 15) begin
                chk_v(4'(rx_invert), 4'(w[0]));
            end
        end
        load({22'($urandom), 9'h084});
        hv = 1'b1;
        falls(2);
        chk_v(4'(mode), 4'h3);
        falls(1);
        chk_v(4'(mode), 4'h1);
        chk_v(4'(time_oe), 4'h1);
        falls(2);
        chk_v(4'(mode), 4'h1);
        prog_sel = 1'b1;
        tick(3);
        chk_v(4'(mode), 4'h2);
        hv = 1'b0;
        prog_sel = 1'b0;
        tick(3);
        chk_v(4'(mode), 4'h5);
        hv = 1'b1;
        tick(3);
        chk_v(4'(mode), 4'h3);
        hv = 1'b0;
        w = {22'($urandom), 9'h1C0 | 9'($urandom_range(1, 0))};
        pace = 2'h2;
        tick(2);
        push_word(w, 3);
        load(w);
        drain();
        pace = 2'h0;
        w = {22'($urandom), 9'h181 | (9'($urandom) & 9'h030)};
        load(w);
        tick(20);
        chk_v(4'(ser_valid), 4'h0);
        push_word(w, 1);
        time_in = 1'b0;
        drain();
        time_in = 1'b1;
        summarize();
    end
endmodule
